// ---- include/eoc_regs.vh ----
// register offsets, field positions, reset values and timing counts of the external oscillator control
`ifndef EOC_REGS_VH
`define EOC_REGS_VH
// word byte addresses on the avalon bus (printed offset is not a multiple of four, so index times four)
`define EOC_IDX_CONTROL      8'hb1
`define EOC_IDX_STATUS       8'hb2
`define EOC_IDX_MASK         8'hb3
`define EOC_IDX_TIMER_SEL    8'hb4
`define EOC_ADDR_CONTROL     10'h2c4
`define EOC_ADDR_STATUS      10'h2c8
`define EOC_ADDR_MASK        10'h2cc
`define EOC_ADDR_TIMER_SEL   10'h2d0
// control register fields
`define EOC_VALID_BIT        7
`define EOC_MODE_HI          6
`define EOC_MODE_LO          4
`define EOC_RANGE_HI         2
`define EOC_RANGE_LO         0
`define EOC_CONTROL_RESET    8'h00
// mode encodings
`define EOC_MODE_OFF         3'h0
`define EOC_MODE_CMOS        3'h2
`define EOC_MODE_CMOS_DIV2   3'h3
`define EOC_MODE_RC          3'h4
`define EOC_MODE_CAP         3'h5
`define EOC_MODE_XTAL        3'h6
`define EOC_MODE_XTAL_DIV2   3'h7
// status bits
`define EOC_ST_VALID_RISE    0
`define EOC_ST_VALID_FALL    1
`define EOC_ST_TICK          2
// timer source select bits
`define EOC_SEL_TIMER        0
`define EOC_SEL_COUNTER      1
// settle time for the amplitude detector
`define EOC_SETTLE_US        1000
`define EOC_CLK_MHZ          100
`define EOC_SETTLE_CYCLES    (`EOC_SETTLE_US * `EOC_CLK_MHZ)
`endif

// ---- logic/eoc_sync_div.v ----
// synchroniser and divide-by-eight of the external oscillator clock
`timescale 1ns/1ps
module eoc_sync_div #(
   parameter DIV_LOG2 = 3                 // divide by two to this power
) (
   input  wire clk,
   input  wire srst,
   input  wire ext_clk,                   // raw external clock level
   input  wire enable,                    // oscillator running
   output reg  tick                       // one system cycle per divided period
);
   reg                ext_s1;             // first synchroniser stage
   reg                ext_s2;             // second stage
   reg                ext_s3;             // edge history
   reg [DIV_LOG2-1:0] div_cnt;            // rising edge counter

   // two flops, then edge detect on the stable stage
   always @(posedge clk) begin
      if (srst) begin
         ext_s1  <= 1'b0;
         ext_s2  <= 1'b0;
         ext_s3  <= 1'b0;
         div_cnt <= {DIV_LOG2{1'b0}};
         tick    <= 1'b0;
      end else begin
         ext_s1 <= ext_clk;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         tick   <= 1'b0;
         if (!enable) begin
            div_cnt <= {DIV_LOG2{1'b0}};
         end else if (ext_s2 && !ext_s3) begin
            div_cnt <= div_cnt + {{(DIV_LOG2-1){1'b0}}, 1'b1};
            // eighth edge gives one tick, aligned to a system edge
            if (&div_cnt) begin
               tick <= 1'b1;
            end
         end
      end
   end
endmodule // eoc_sync_div

// ---- logic/eoc_top.v ----
// external oscillator control: register, pin claim, valid flag, divided timer clock, interrupt
// How it works
// - divided-by-8 clock offered to timers, counter array
// - divided clock synchronised, jitter within one system cycle
// - read-only valid flag in bit 7
// - crystal claims two pins, other modes except off only output
// - 010 CMOS clock, 011 CMOS divided by two
`timescale 1ns/1ps
`include "eoc_regs.vh"
module eoc_top #(
   parameter SETTLE_CYCLES = `EOC_SETTLE_CYCLES    // amplitude settle time in system cycles
) (
   input  wire        clk,
   input  wire        srst,
   input  wire [9:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        osc_pin_in,                   // amplifier input side pin level
   input  wire        osc_pin_out,                  // output side pin level / clock input
   input  wire        amp_ok,                       // amplitude detector says oscillation present
   output reg         claim_pin_in,                 // pin taken as oscillator input
   output reg         claim_pin_out,                // pin taken as oscillator output
   output reg         drive_en,                     // drive circuit powered
   output reg  [2:0]  ext_osc_range_ctrl,           // to the analog drive
   output reg  [2:0]  ext_osc_mode_sel,             // to the analog drive
   output reg         timer_ext_tick,               // divided clock pulse for timers
   output reg         counter_ext_tick,             // divided clock pulse for counter array
   output reg         irq
);
   reg  [2:0]  mode;             // mode field
   reg  [2:0]  range;            // range field
   reg  [2:0]  status;           // sticky events
   reg  [2:0]  mask;             // interrupt mask
   reg  [1:0]  tsel;             // tick routing
   reg         crystal_valid_flag;
   reg  [31:0] settle_cnt;       // settle counter
   reg         amp_s1;           // detector synchroniser
   reg         amp_s2;
   reg         half;             // cmos divide-by-two phase
   reg         ack;              // answer phase of a bus access
   wire        tick;
   wire        is_xtal;
   wire        sel_in;
   wire        ext_clk;
   wire        wr_go;
   wire        rd_go;
   wire [2:0]  next_status;
   wire        next_valid;
   reg  [31:0] next_rdata;
   localparam [7:0] CTRL_RESET = `EOC_CONTROL_RESET;   // control value after reset

   assign is_xtal = (mode == `EOC_MODE_XTAL) || (mode == `EOC_MODE_XTAL_DIV2);
   // crystal is sampled on the input side, other modes on the output side
   assign sel_in  = is_xtal;
   assign ext_clk = sel_in ? osc_pin_in : osc_pin_out;
   assign wr_go   = avs_write && !ack;
   assign rd_go   = avs_read && !ack;

   // one waitrequest cycle then answer
   always @(posedge clk) begin
      if (srst) begin
         ack             <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack             <= (avs_read || avs_write) && !ack;
         avs_waitrequest <= !((avs_read || avs_write) && !ack);
      end
   end

   // cmos divide-by-two stage after the divider, toggled by each tick
   always @(posedge clk) begin
      if (srst) begin
         half <= 1'b0;
      end else if (tick) begin
         half <= ~half;
      end
   end

   // divide by eight and synchronise
   eoc_sync_div #(
      .DIV_LOG2 (3)
   ) u_div (
      .clk     (clk),
      .srst    (srst),
      .ext_clk (ext_clk),
      .enable  (mode != `EOC_MODE_OFF),
      .tick    (tick)
   );

   // valid flag only after detector steady for the settle time
   always @(posedge clk) begin
      if (srst) begin
         amp_s1             <= 1'b0;
         amp_s2             <= 1'b0;
         settle_cnt         <= 32'h0000_0000;
         crystal_valid_flag <= 1'b0;
      end else begin
         amp_s1 <= amp_ok;
         amp_s2 <= amp_s1;
         if (!is_xtal || !amp_s2) begin
            settle_cnt <= 32'h0000_0000;
         end else if (settle_cnt != SETTLE_CYCLES) begin
            settle_cnt <= settle_cnt + 32'h0000_0001;
         end
         crystal_valid_flag <= next_valid;
      end
   end
   assign next_valid = is_xtal && amp_s2 && (settle_cnt == SETTLE_CYCLES);

   // events: set beats write-one-to-clear
   assign next_status[`EOC_ST_VALID_RISE] = next_valid && !crystal_valid_flag;
   assign next_status[`EOC_ST_VALID_FALL] = !next_valid && crystal_valid_flag;
   assign next_status[`EOC_ST_TICK]       = tick;

   // register writes
   always @(posedge clk) begin
      if (srst) begin
         // fields cut from the reset image of the control register
         mode   <= CTRL_RESET[`EOC_MODE_HI:`EOC_MODE_LO];
         range  <= CTRL_RESET[`EOC_RANGE_HI:`EOC_RANGE_LO];
         status <= 3'h0;
         mask   <= 3'h0;
         tsel   <= 2'h0;
      end else begin
         status <= status | next_status;
         if (wr_go && avs_byteenable[0]) begin
            case (avs_address)
               `EOC_ADDR_CONTROL: begin
                  mode  <= avs_writedata[`EOC_MODE_HI:`EOC_MODE_LO];
                  range <= avs_writedata[`EOC_RANGE_HI:`EOC_RANGE_LO];
               end
               `EOC_ADDR_STATUS: begin
                  status <= (status & ~avs_writedata[2:0]) | next_status;
               end
               `EOC_ADDR_MASK: begin
                  mask <= avs_writedata[2:0];
               end
               `EOC_ADDR_TIMER_SEL: begin
                  tsel <= avs_writedata[1:0];
               end
               default: begin
                  mode <= mode;
               end
            endcase
         end
      end
   end

   // read mux, unmapped reads zero
   always @* begin
      next_rdata = 32'h0000_0000;
      case (avs_address)
         `EOC_ADDR_CONTROL:   next_rdata = {24'h000000, crystal_valid_flag, mode, 1'b0, range};
         `EOC_ADDR_STATUS:    next_rdata = {29'h0, status};
         `EOC_ADDR_MASK:      next_rdata = {29'h0, mask};
         `EOC_ADDR_TIMER_SEL: next_rdata = {30'h0, tsel};
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   // registered outputs
   always @(posedge clk) begin
      if (srst) begin
         avs_readdata       <= 32'h0000_0000;
         claim_pin_in       <= 1'b0;
         claim_pin_out      <= 1'b0;
         drive_en           <= 1'b0;
         ext_osc_range_ctrl <= 3'h0;
         ext_osc_mode_sel   <= 3'h0;
         timer_ext_tick     <= 1'b0;
         counter_ext_tick   <= 1'b0;
         irq                <= 1'b0;
      end else begin
         if (rd_go) begin
            avs_readdata <= next_rdata;
         end
         claim_pin_in       <= is_xtal;
         claim_pin_out      <= (mode != `EOC_MODE_OFF);
         drive_en           <= (mode != `EOC_MODE_OFF);
         ext_osc_range_ctrl <= range;
         ext_osc_mode_sel   <= mode;
         // cmos divide-by-two mode passes every second tick
         timer_ext_tick   <= tick && tsel[`EOC_SEL_TIMER] &&
                             ((mode != `EOC_MODE_CMOS_DIV2) || half);
         counter_ext_tick <= tick && tsel[`EOC_SEL_COUNTER] &&
                             ((mode != `EOC_MODE_CMOS_DIV2) || half);
         irq              <= |(status & mask);
      end
   end
endmodule // eoc_top

// ---- dv/eoc_sva.sv ----
// port assertions for the external oscillator control
`timescale 1ns/1ps
module eoc_sva (
   input wire        clk,
   input wire        srst,
   input wire [9:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire        claim_pin_in,
   input wire        claim_pin_out,
   input wire        drive_en,
   input wire [2:0]  ext_osc_range_ctrl,
   input wire [2:0]  ext_osc_mode_sel,
   input wire        timer_ext_tick,
   input wire        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // a fresh request, then one wait cycle and the answer
   sequence s_req; $rose(avs_read || avs_write); endsequence
   sequence s_answer; avs_waitrequest ##1 !avs_waitrequest; endsequence
   a_answer_one_wait: assert property (s_req |-> s_answer)
      else $error("answer not after one wait cycle");
   a_wait_low_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_claim_in_xtal: assert property (claim_pin_in == (ext_osc_mode_sel[2:1] == 2'b11))
      else $error("input pin claim wrong");
   a_claim_out_mode: assert property (claim_pin_out == (ext_osc_mode_sel != 3'h0))
      else $error("output pin claim wrong");
   a_drive_off_idle: assert property (drive_en == (ext_osc_mode_sel != 3'h0))
      else $error("drive power wrong");
   a_valid_needs_xtal: assert property (!avs_waitrequest && avs_read && avs_address == 10'h2c4
      && avs_readdata[7] |-> claim_pin_in) else $error("valid seen outside crystal mode");
   a_tick_one_pulse: assert property (timer_ext_tick |=> !timer_ext_tick [*8])
      else $error("divided ticks too close");
   a_fields_by_write: assert property (!$stable({ext_osc_mode_sel, ext_osc_range_ctrl}) |-> $past(avs_write))
      else $error("fields changed without a write");
   a_irq_masked_off: assert property (avs_write && !avs_waitrequest && avs_address == 10'h2cc
      && avs_writedata[2:0] == 3'h0 |=> !irq) else $error("irq up with empty mask");
endmodule // eoc_sva

// ---- dv/eoc_osc_model.sv ----
// behavioural external oscillator: pin clock and amplitude detector
`timescale 1ns/1ps
module eoc_osc_model #(
   parameter HALF    = 3,              // half period in system cycles
   parameter AMP_DLY = 10              // cycles until amplitude is good
) (
   input  wire clk,
   input  wire drive_en,               // drive circuit powered
   output reg  osc_pin_in,             // amplifier input side
   output reg  osc_pin_out,            // output side, cmos clock
   output reg  amp_ok                  // oscillation present
);
   integer ph = 0;                     // phase count
   integer up = 0;                     // cycles since power up
   initial begin
      osc_pin_in = 1'b1;
      osc_pin_out = 1'b0;
      amp_ok = 1'b0;
   end
   // runs only while driven, never faster than the system clock
   always @(posedge clk) begin
      up = drive_en ? up + 1 : 0;
      ph = drive_en ? (ph + 1) % HALF : 0;
      amp_ok <= (up > AMP_DLY);
      if (drive_en && ph == 0) osc_pin_out <= ~osc_pin_out;
      osc_pin_in <= ~osc_pin_out;
   end
endmodule // eoc_osc_model

// ---- dv/tb_eoc_top.sv ----
// self-checking bench for the external oscillator control
`timescale 1ns/1ps
`include "eoc_regs.vh"
module tb_eoc_top;
   logic        clk, srst, avs_read, avs_write, avs_waitrequest;   // bus control
   logic [9:0]  avs_address;                                        // register address
   logic [31:0] avs_writedata, avs_readdata, q;                     // bus data
   logic        osc_pin_in, osc_pin_out, amp_ok, irq;               // model and interrupt
   logic        claim_pin_in, claim_pin_out, drive_en, timer_ext_tick, counter_ext_tick;
   logic [2:0]  ext_osc_range_ctrl, ext_osc_mode_sel, r;            // field copies
   int          errors = 0, checks_done = 0, nt = 0, nc = 0, t0, c0; // counters
   eoc_top #(.SETTLE_CYCLES(20)) eoc_top_inst (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .osc_pin_in, .osc_pin_out, .amp_ok, .claim_pin_in,
      .claim_pin_out, .drive_en, .ext_osc_range_ctrl, .ext_osc_mode_sel, .timer_ext_tick, .counter_ext_tick, .irq);
   eoc_osc_model eoc_osc_model_inst (.clk, .drive_en, .osc_pin_in, .osc_pin_out, .amp_ok);
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // one avalon cycle, held until waitrequest is sampled low
   // no cycle limit here: only the watchdog ends a wait
   task automatic bus(bit w, logic [9:0] a, logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // tick counters for the two routes
   always @(posedge clk) begin
      nt <= nt + (timer_ext_tick === 1'b1);
      nc <= nc + (counter_ext_tick === 1'b1);
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop;
   end
   initial begin
      {srst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 10'h0, 32'h0};
      void'($urandom(41825));
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      bus(0, `EOC_ADDR_CONTROL, 0);
      chk("control reset", 32'h0, q);
      bus(1, 10'h3fc, 32'hff);
      bus(0, 10'h3fc, 0);
      chk("unmapped", 32'h0, q);
      $display("test reset done");
      // every mode with a random range, read-only bits written high
      for (int m = 0; m < 8; m++) begin
         r = 3'($urandom % 8);
         bus(1, `EOC_ADDR_CONTROL, {24'h0, 1'b1, m[2:0], 1'b1, r});
         bus(0, `EOC_ADDR_CONTROL, 0);
         chk("control", {24'h0, 1'b0, m[2:0], 1'b0, r}, q);
         chk("claims", {m[2:1] == 2'b11, m != 0, m != 0}, {claim_pin_in, claim_pin_out, drive_en});
         chk("copies", {m[2:0], r}, {ext_osc_mode_sel, ext_osc_range_ctrl});
      end
      $display("test modes done");
      repeat (60) @(posedge clk);
      bus(0, `EOC_ADDR_CONTROL, 0);
      chk("valid", {24'h0, 1'b1, 3'h7, 1'b0, r}, q);
      bus(0, `EOC_ADDR_STATUS, 0);
      chk("valid rose", 32'h1, q[0]);
      bus(1, `EOC_ADDR_MASK, 32'h1);
      @(posedge clk);
      chk("irq up", 32'h1, irq);
      $display("test valid done");
      // cmos clock then cmos halved, each to one route
      for (int k = 2; k < 4; k++) begin
         bus(1, `EOC_ADDR_TIMER_SEL, k - 1);
         bus(1, `EOC_ADDR_CONTROL, k << 4);
         t0 = nt;
         c0 = nc;
         repeat (384) @(posedge clk);
         chk("timer ticks", 1, (nt - t0 - (k == 2 ? 8 : 0)) inside {-1, 0, 1});
         chk("counter ticks", 1, (nc - c0 - (k == 3 ? 4 : 0)) inside {-1, 0, 1});
      end
      bus(1, `EOC_ADDR_MASK, 32'h0);
      @(posedge clk);
      chk("irq masked", 32'h0, irq);
      bus(0, `EOC_ADDR_STATUS, 0);
      chk("tick seen", 32'h6, q & 32'h6);
      bus(1, `EOC_ADDR_CONTROL, 32'h0);
      repeat (8) @(posedge clk);
      bus(1, `EOC_ADDR_STATUS, 32'h7);
      bus(1, `EOC_ADDR_MASK, 32'h7);
      bus(0, `EOC_ADDR_STATUS, 0);
      chk("cleared", 32'h0, q);
      bus(0, `EOC_ADDR_CONTROL, 0);
      chk("off", 32'h0, q);
      chk("irq low", 32'h0, irq);
      $display("test ticks done");
      report_and_stop;
   end
endmodule // tb_eoc_top
bind eoc_top eoc_sva eoc_sva_inst (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
   .avs_waitrequest, .claim_pin_in, .claim_pin_out, .drive_en, .ext_osc_range_ctrl, .ext_osc_mode_sel,
   .timer_ext_tick, .irq);
